// file: core/fspm_defines.svh
// Purpose: constants for the fault status and protection monitor
// Assumes: included by its bare name
// Notes:   fault summary bit positions, decode codes, delays
`ifndef FSPM_DEFINES_SVH
`define FSPM_DEFINES_SVH
`define FSPM_BIT_OTHER      0
`define FSPM_BIT_LOGIC      1
`define FSPM_BIT_TEMP       2
`define FSPM_BIT_INPUT      3
`define FSPM_BIT_OVERCUR    4
`define FSPM_BIT_OVERVOLT   5
`define FSPM_BIT_OFF        6
`define FSPM_BIT_BUSY       7
`define FSPM_STATUS_RESET   8'h00
`define FSPM_CODE_ZERO      4'h0
`define FSPM_HICCUP_OFF_NS  1000
`define FSPM_CLK_NS         100
`define FSPM_HICCUP_CYC     ((`FSPM_HICCUP_OFF_NS + `FSPM_CLK_NS - 1) / `FSPM_CLK_NS)
`endif

// file: core/fspm_pkg.sv
// Purpose: types for the fault status and protection monitor
// Assumes: nothing
// Notes:   hiccup sequencer states, one-hot
package fspm_pkg;
  typedef enum logic [2:0] {
    FSPM_RUN   = 3'b001,
    FSPM_STOP  = 3'b010,
    FSPM_RETRY = 3'b100
  } fspm_hiccup_e;
  typedef logic [7:0] fspm_byte_t;
endpackage

// file: core/fault_status_protection_monitor.sv
// Purpose: fault latching, fault pin and protection gating of the converter
// Assumes: all inputs deglitched and synchronous to core_clk
// Notes:   status bus strobes come from an external serial target
//
// Overview of operation
// - odd decode codes enable spread spectrum select
// - busy bit follows internal register ownership
// - off bit: low output or system off
// - overvoltage flag latched until cleared
// - overcurrent flag latched on peak limit
// - input fault flag latched on undervoltage
// - temperature flag latched on shutdown/warning
// - logic fault flag set on checksum error
// - average limit active gated by enable
// - fault mode: pin asserts on summary faults
// - fault mode: pin releases when the live fault is gone or on restart
// - interrupt mode: pin toggles on changes
// - clear register access or write-one clears
// - thermal shutdown stops converter until cool
// - hiccup: stop then restart on short
// - feedback guard masked in sleep/softstart/internal
// - absolute guard tristates switch nodes
// - input guard blocks forced pulse mode
// - regulation needs both enables, pauses mode-low
// - checksum mismatch holds converter off state
// - decodes latched at power-up until reset
// - channel three only without serial bus
`include "fspm_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module fault_status_protection_monitor #(
  parameter int HICCUP_CYC = `FSPM_HICCUP_CYC   // converter off time in hiccup
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             powerUpDone,        // decode sample strobe level
  input  wire logic             serialBusEnable,    // serial bus function active
  input  wire logic [3:0]       configPinThreeCode, // resistor_decode channel three
  input  wire logic             startupDone,
  input  wire logic             regFieldBusy,
  input  wire logic             outputBelowPowerGood,
  input  wire logic             systemOff,
  input  wire logic             feedbackOvTrip,
  input  wire logic             absoluteOvTrip,
  input  wire logic             peakLimitTrip,
  input  wire logic             inputVoltageDetectLow,
  input  wire logic             uvloSenseLow,
  input  wire logic             thermalShutdown,
  input  wire logic             thermalWarning,
  input  wire logic             checksumMismatch,
  input  wire logic             bootDone,
  input  wire logic             avgLimitEnable,
  input  wire logic             avgLimitReached,
  input  wire logic [7:0]       pdInputs,           // inputs of pd_status_reg0
  input  wire logic             microSleep,
  input  wire logic             softStart,
  input  wire logic             internalFeedback,
  input  wire logic             hiccupEnable,
  input  wire logic             inputOvGuardEnable,
  input  wire logic             inputOvAbove,
  input  wire logic             inputRegulationEnable,
  input  wire logic             modePinLow,
  input  wire logic             forcedPwmRequest,
  input  wire logic             interruptModeSelect,
  input  wire logic             clearRegAccess,     // read or write of clear register
  input  wire logic             statusWrite,        // write strobe of summary byte
  input  wire logic [7:0]       statusWriteData,
  output fspm_pkg::fspm_byte_t  faultSummary,
  output fspm_pkg::fspm_byte_t  pdStatusReg0,
  output logic                  avgLimitActive,
  output logic                  spreadSpectrumSelect,
  output logic                  decodeValid,
  output logic                  faultPinOut,        // always drives low when enabled
  output logic                  faultPinOe,
  output logic                  converterEnable,
  output logic                  switchNodesHighZ,
  output logic                  forcedPwmAllowed,
  output logic                  inputRegulationActive,
  output logic                  converterOffState
);
  import fspm_pkg::*;

  // decoded spread spectrum bit for one code: odd codes are enabled
  function automatic logic ssDecode(input logic [3:0] code);
    ssDecode = code[0];
  endfunction

  fspm_byte_t   next_summary;                 // next latched summary
  fspm_byte_t   instant;                      // instantaneous summary inputs
  fspm_byte_t   prevInstant;                  // last cycle's instant inputs
  fspm_byte_t   prevPd;                       // last cycle's pd inputs
  fspm_byte_t   clearMask;                    // bits to clear this cycle
  fspm_hiccup_e hiccupState;                  // hiccup sequencer
  fspm_hiccup_e next_hiccupState;
  logic [15:0]  hiccupCount;                  // off-time counter
  logic         decodeAllowed;                // channel three usable
  logic         feedbackOvSeen;               // feedback guard after masking
  logic         anyChange;                    // interrupt mode change event
  logic         bootChecked;                  // checksum gate latched after boot
  logic         bootBad;

  assign decodeAllowed = !serialBusEnable;
  assign feedbackOvSeen = feedbackOvTrip && !microSleep && !softStart
                          && !internalFeedback;

  // instantaneous inputs; busy and off only observed after start-up
  assign instant[`FSPM_BIT_BUSY]     = startupDone && regFieldBusy;
  assign instant[`FSPM_BIT_OFF]      = startupDone && (outputBelowPowerGood || systemOff);
  assign instant[`FSPM_BIT_OVERVOLT] = feedbackOvSeen || absoluteOvTrip;
  assign instant[`FSPM_BIT_OVERCUR]  = peakLimitTrip;
  assign instant[`FSPM_BIT_INPUT]    = inputVoltageDetectLow || uvloSenseLow;
  assign instant[`FSPM_BIT_TEMP]     = thermalShutdown || thermalWarning;
  assign instant[`FSPM_BIT_LOGIC]    = checksumMismatch;
  assign instant[`FSPM_BIT_OTHER]    = 1'b0;

  // clear mask: whole byte on clear register access, else write-one bits
  assign clearMask = clearRegAccess ? 8'hFF :
                     (statusWrite ? statusWriteData : 8'h00);

  // set wins over clear so a same-cycle event is never lost
  always_comb begin
    next_summary = (faultSummary & ~clearMask) | instant;
    // busy and off are live levels, not latched
    next_summary[`FSPM_BIT_BUSY] = instant[`FSPM_BIT_BUSY];
    next_summary[`FSPM_BIT_OFF]  = instant[`FSPM_BIT_OFF];
  end

  // summary register and edge history
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      faultSummary <= `FSPM_STATUS_RESET;
      prevInstant  <= 8'h00;
      prevPd       <= 8'h00;
    end else begin
      faultSummary <= next_summary;
      prevInstant  <= instant;
      prevPd       <= pdInputs;
    end
  end

  // average limit flag passes straight into the pd byte
  assign avgLimitActive = avgLimitEnable && avgLimitReached;
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      pdStatusReg0 <= 8'h00;
    end else begin
      pdStatusReg0 <= {pdInputs[7:1], avgLimitActive};
    end
  end

  // decode latch: captured once at power-up, held until reset
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      decodeValid          <= 1'b0;
      spreadSpectrumSelect <= 1'b0;
    end else if (powerUpDone && !decodeValid) begin
      decodeValid          <= 1'b1;
      spreadSpectrumSelect <= decodeAllowed && ssDecode(configPinThreeCode);
    end
  end

  // interrupt mode: any change of instant or pd inputs toggles the pin
  assign anyChange = (instant != prevInstant) || (pdInputs != prevPd);
  logic intLevel;                             // toggling interrupt level
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      intLevel <= 1'b0;
    end else if (anyChange) begin
      intLevel <= !intLevel;
    end
  end

  // fault mode drives low while a live fault exists and the converter is not
  // restarting; releases once the condition is gone or during the restart pulse
  logic faultLive;
  assign faultLive = |instant[`FSPM_BIT_OVERVOLT:`FSPM_BIT_LOGIC]
                     || instant[`FSPM_BIT_OFF];
  assign faultPinOut = 1'b0;
  assign faultPinOe  = interruptModeSelect ? intLevel
                       : (faultLive && hiccupState != FSPM_RETRY);

  // checksum gate evaluated once after the boot phase
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      bootChecked <= 1'b0;
      bootBad     <= 1'b0;
    end else if (bootDone && !bootChecked) begin
      bootChecked <= 1'b1;
      bootBad     <= checksumMismatch;
    end
  end
  assign converterOffState = !bootChecked || bootBad;

  // hiccup sequencer: stop for a fixed time, then retry
  always_comb begin
    next_hiccupState = hiccupState;
    unique case (hiccupState)
      FSPM_RUN:   if (hiccupEnable && peakLimitTrip) next_hiccupState = FSPM_STOP;
      FSPM_STOP:  if (hiccupCount == 16'(HICCUP_CYC - 1)) next_hiccupState = FSPM_RETRY;
      FSPM_RETRY: next_hiccupState = FSPM_RUN;  // restart pulse
    endcase
  end
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      hiccupState <= FSPM_RUN;
      hiccupCount <= 16'h0000;
    end else begin
      hiccupState <= next_hiccupState;
      hiccupCount <= (hiccupState == FSPM_STOP) ? hiccupCount + 16'h0001 : 16'h0000;
    end
  end

  // converter gating; feedback guard alone never stops it
  assign switchNodesHighZ = absoluteOvTrip;
  assign converterEnable  = !converterOffState && !thermalShutdown
                            && !absoluteOvTrip && hiccupState == FSPM_RUN;
  assign forcedPwmAllowed = forcedPwmRequest
                            && !(inputOvGuardEnable && inputOvAbove);
  assign inputRegulationActive = inputOvGuardEnable && inputRegulationEnable
                                 && !modePinLow && forcedPwmRequest;

  // assertions
  a_ov_latch_holds: assert property (@(posedge core_clk) disable iff (rst)
    faultSummary[`FSPM_BIT_OVERVOLT] && !clearRegAccess && !statusWrite
    |=> faultSummary[`FSPM_BIT_OVERVOLT])
    else $error("overvoltage flag dropped without clear");
  a_oc_sets: assert property (@(posedge core_clk) disable iff (rst)
    peakLimitTrip |=> faultSummary[`FSPM_BIT_OVERCUR])
    else $error("overcurrent flag not set");
  a_clear_all: assert property (@(posedge core_clk) disable iff (rst)
    clearRegAccess && instant == 8'h00 |=> faultSummary == 8'h00)
    else $error("clear access left faults");
  a_temp_sets: assert property (@(posedge core_clk) disable iff (rst)
    (thermalShutdown || thermalWarning) |=> faultSummary[`FSPM_BIT_TEMP])
    else $error("temperature flag not set");
  a_tsd_stops: assert property (@(posedge core_clk) disable iff (rst)
    thermalShutdown |-> !converterEnable)
    else $error("converter runs in thermal shutdown");
  a_absolute_overvoltage_guard_tristate: assert property (@(posedge core_clk) disable iff (rst)
    absoluteOvTrip |-> switchNodesHighZ && !converterEnable)
    else $error("power stage active on absolute overvoltage");
  a_ivp_blocks: assert property (@(posedge core_clk) disable iff (rst)
    inputOvGuardEnable && inputOvAbove |-> !forcedPwmAllowed)
    else $error("forced pwm allowed above input threshold");
  a_hiccup_stop: assert property (@(posedge core_clk) disable iff (rst)
    hiccupState == FSPM_RUN && hiccupEnable && peakLimitTrip |=> !converterEnable)
    else $error("hiccup did not stop converter");
  a_int_toggle: assert property (@(posedge core_clk) disable iff (rst)
    anyChange |=> intLevel != $past(intLevel))
    else $error("interrupt level did not toggle");
  a_avg_gate: assert property (@(posedge core_clk) disable iff (rst)
    !avgLimitEnable |=> !pdStatusReg0[0])
    else $error("average limit shown while disabled");

  // live and latched bits of the summary and pd bytes
  // busy must show one cycle after ownership is seen
  a_busy_live: assert property (@(posedge core_clk) disable iff (rst)
    startupDone && regFieldBusy |=> faultSummary[`FSPM_BIT_BUSY])
    else $error("busy bit missing");
  // off is hidden until start-up completes
  a_off_gated: assert property (@(posedge core_clk) disable iff (rst)
    !startupDone |=> !faultSummary[`FSPM_BIT_OFF])
    else $error("off bit shown before start-up");
  // system off request shows in the off bit
  a_off_sets: assert property (@(posedge core_clk) disable iff (rst)
    startupDone && systemOff |=> faultSummary[`FSPM_BIT_OFF])
    else $error("off bit not set on system off");
  // input undervoltage latches the input flag
  a_input_sets: assert property (@(posedge core_clk) disable iff (rst)
    inputVoltageDetectLow || uvloSenseLow |=> faultSummary[`FSPM_BIT_INPUT])
    else $error("input flag not set");
  // checksum error latches the logic flag
  a_logic_sets: assert property (@(posedge core_clk) disable iff (rst)
    checksumMismatch |=> faultSummary[`FSPM_BIT_LOGIC])
    else $error("logic fault flag not set");
  // the unused position never reads high
  a_unused_zero: assert property (@(posedge core_clk) disable iff (rst)
    1'b1 |-> !faultSummary[`FSPM_BIT_OTHER])
    else $error("unused summary bit set");
  // overcurrent stays latched without a clear
  a_oc_holds: assert property (@(posedge core_clk) disable iff (rst)
    faultSummary[`FSPM_BIT_OVERCUR] && !clearRegAccess && !statusWrite
    |=> faultSummary[`FSPM_BIT_OVERCUR])
    else $error("overcurrent flag dropped without clear");
  // write-one clears a bit whose source is gone
  a_wr_clears: assert property (@(posedge core_clk) disable iff (rst)
    statusWrite && statusWriteData[`FSPM_BIT_TEMP] && !thermalShutdown && !thermalWarning
    |=> !faultSummary[`FSPM_BIT_TEMP])
    else $error("write-one did not clear temperature flag");
  // masked feedback guard never raises the flag by itself
  a_fb_masked: assert property (@(posedge core_clk) disable iff (rst)
    (microSleep || softStart || internalFeedback) && !absoluteOvTrip
    && !faultSummary[`FSPM_BIT_OVERVOLT] |=> !faultSummary[`FSPM_BIT_OVERVOLT])
    else $error("masked feedback guard raised the flag");
  // reached limit with enable shows in the pd byte
  a_avg_shows: assert property (@(posedge core_clk) disable iff (rst)
    avgLimitEnable && avgLimitReached |=> pdStatusReg0[0])
    else $error("average limit not shown");

  // protection gating, decode latch and pin
  // regulation needs both enables and a high mode pin
  a_ivr_gate: assert property (@(posedge core_clk) disable iff (rst)
    !(inputOvGuardEnable && inputRegulationEnable) || modePinLow |-> !inputRegulationActive)
    else $error("input regulation active without its enables");
  // a bad checksum keeps the converter off
  a_crc_off: assert property (@(posedge core_clk) disable iff (rst)
    bootChecked && bootBad |-> converterOffState && !converterEnable)
    else $error("converter left off state after bad checksum");
  // captured decode never moves until reset
  a_decode_hold: assert property (@(posedge core_clk) disable iff (rst)
    decodeValid |=> $stable(spreadSpectrumSelect))
    else $error("decode changed after capture");
  // serial bus in use forces channel three off
  a_bus_blocks: assert property (@(posedge core_clk) disable iff (rst)
    !decodeValid && powerUpDone && serialBusEnable |=> !spreadSpectrumSelect)
    else $error("spread spectrum taken while bus in use");
  // a live logic fault pulls the pin in fault mode
  a_pin_fault: assert property (@(posedge core_clk) disable iff (rst)
    !interruptModeSelect && checksumMismatch && hiccupState != FSPM_RETRY |-> faultPinOe)
    else $error("fault pin not asserted");
  // restart pulse releases the pin in fault mode
  a_pin_release: assert property (@(posedge core_clk) disable iff (rst)
    !interruptModeSelect && hiccupState == FSPM_RETRY |-> !faultPinOe)
    else $error("fault pin held during restart");
  // no input change, no pin change in interrupt mode
  a_pin_quiet: assert property (@(posedge core_clk) disable iff (rst)
    interruptModeSelect && !anyChange ##1 interruptModeSelect |-> $stable(faultPinOe))
    else $error("interrupt pin moved without a change");
  // retry lasts exactly one cycle before running again
  a_retry_once: assert property (@(posedge core_clk) disable iff (rst)
    hiccupState == FSPM_RETRY |=> hiccupState == FSPM_RUN)
    else $error("hiccup retry did not return to run");
endmodule
`default_nettype wire

// file: tb/fspm_host_model.sv
// Purpose: serial host stand-in that clears faults and watches the fault pin
// Assumes: strobes launched at the falling edge, one cycle wide
// Notes:   pin level resolved here with the board pull-up
`timescale 1ns/1ps
`default_nettype none
module fspm_host_model (
  input  wire logic       core_clk,
  input  wire logic [7:0] faultSummary,        // busy bit read before writes
  input  wire logic       converterOffState,   // mode changes only when set
  input  wire logic       faultPinOe,          // device sinks the pin
  output logic            clearRegAccess,      // clear register touched
  output logic            statusWrite,         // summary byte write
  output logic [7:0]      statusWriteData,     // write-one-to-clear mask
  output logic            interruptModeSelect, // 0 fault, 1 interrupt
  output logic            pinLevel             // resolved open-drain level
);
  // pull-up wins unless the device sinks the pin
  assign pinLevel = faultPinOe ? 1'h0 : 1'h1;
  // idle bus at time zero
  initial begin
    {clearRegAccess, statusWrite, statusWriteData, interruptModeSelect} = '0;
  end
  // one access of the clear register
  task automatic clearAll();
    @(negedge core_clk) clearRegAccess = 1'h1;
    @(negedge core_clk) clearRegAccess = 1'h0;
  endtask
  // write-one-to-clear; waits out busy, bounded so a stuck bit cannot hang us
  task automatic writeOnes(input logic [7:0] wMask);
    int n = 0;
    @(negedge core_clk);
    while (faultSummary[7] === 1'h1 && n < 50) begin
      n++;
      @(negedge core_clk);
    end
    statusWrite     = 1'h1;
    statusWriteData = wMask;
    @(negedge core_clk) statusWrite = 1'h0;
  endtask
  // mode is only touched while the converter sits in its off state
  task automatic setMode(input logic m);
    @(negedge core_clk);
    if (converterOffState === 1'h1) interruptModeSelect = m;
  endtask
endmodule
`default_nettype wire

// file: tb/test_fault_status_protection_monitor.sv
// Purpose: self-checking bench for the fault status and protection monitor
// Assumes: inputs driven at the falling edge of core_clk
// Notes:   short hiccup off time keeps the run brief
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin nTests++; if ((a) !== (e)) begin numErrors++; \
  $display("[ERR] %0t got %0h exp %0h", $time, (a), (e)); end end
module test_fault_status_protection_monitor;
  localparam int HIC = 2; // short hiccup off time
  logic       core_clk, rst, powerUpDone, serialBusEnable, startupDone, regFieldBusy;
  logic       outputBelowPowerGood, systemOff, thermalShutdown, checksumMismatch, bootDone;
  logic       avgLimitEnable, avgLimitReached, inputOvGuardEnable, inputOvAbove, modePinLow;
  logic       inputRegulationEnable, forcedPwmRequest, interruptModeSelect, clearRegAccess;
  logic       statusWrite, avgLimitActive, spreadSpectrumSelect, decodeValid, faultPinOut;
  logic       faultPinOe, converterEnable, switchNodesHighZ, forcedPwmAllowed, pinLevel;
  logic       inputRegulationActive, converterOffState, hiccupEnable;
  logic [3:0] configPinThreeCode;
  logic [7:0] pdInputs, statusWriteData, faultSummary, pdStatusReg0;
  logic [5:0] trip; // one bit per latching fault source
  logic [2:0] mask; // feedback guard masking conditions
  wire        feedbackOvTrip, absoluteOvTrip, peakLimitTrip, inputVoltageDetectLow;
  wire        uvloSenseLow, thermalWarning, microSleep, softStart, internalFeedback;
  int         numErrors, nTests;
  int         bitOf[6] = '{5, 5, 4, 3, 3, 2}; // summary bit of each source
  assign {thermalWarning, uvloSenseLow, inputVoltageDetectLow} = trip[5:3];
  assign {peakLimitTrip, absoluteOvTrip, feedbackOvTrip} = trip[2:0];
  assign {internalFeedback, softStart, microSleep} = mask;
  fault_status_protection_monitor #(.HICCUP_CYC(HIC))
    fault_status_protection_monitor_inst (.*);
  fspm_host_model fspm_host_model_inst (.*);
  // 10 MHz clock
  always #50 core_clk = ~core_clk;
  task automatic nclk(input int n);
    repeat (n) @(negedge core_clk);
  endtask
  // reset with a decode code and a pin mode; decodes sampled on the second rising edge after release
  task automatic resetDut(input logic [3:0] code, input logic mode);
    rst = 1'h1;
    {powerUpDone, bootDone} = 2'h0;
    configPinThreeCode = code;
    nclk(7);
    `CHK(faultSummary, 8'h00)
    `CHK(converterOffState, 1'h1)
    `CHK(faultPinOe, 1'h0)
    fspm_host_model_inst.setMode(mode);
    rst = 1'h0;
    @(negedge core_clk) {powerUpDone, bootDone} = 2'h3;
    nclk(1);
  endtask
  // each source latches its flag; the pin follows only the live fault
  task automatic tLatch();
    for (int i = 0; i < 6; i++) begin
      trip = 6'h01 << i;
      nclk(1);
      `CHK(faultSummary[bitOf[i]], 1'h1)
      `CHK(pinLevel, 1'h0)
      `CHK(faultPinOut, 1'h0)
      trip = 6'h00;
      nclk(1);
      `CHK(faultSummary[bitOf[i]], 1'h1)
      `CHK(pinLevel, 1'h1)
      fspm_host_model_inst.clearAll();
      `CHK(faultSummary, 8'h00)
    end
  endtask
  // live busy and off bits; off only counts after start-up
  task automatic tBusyOff();
    {regFieldBusy, outputBelowPowerGood} = 2'h3;
    nclk(1);
    `CHK(faultSummary, 8'hC0)
    {startupDone, outputBelowPowerGood, regFieldBusy} = 3'h0;
    systemOff = 1'h1;
    nclk(1);
    `CHK(faultSummary, 8'h00)
    startupDone = 1'h1;
    fspm_host_model_inst.writeOnes(8'hC0);
    `CHK(faultSummary, 8'h40)
    systemOff = 1'h0;
    trip = 6'h24; // overcurrent and thermal warning together
    nclk(1);
    trip = 6'h00;
    fspm_host_model_inst.writeOnes(8'h04);
    `CHK(faultSummary, 8'h10)
    fspm_host_model_inst.clearAll();
  endtask
  // stop and resume paths of the converter
  task automatic tProtect();
    `CHK(converterEnable, 1'h1)
    thermalShutdown = 1'h1;
    #1 `CHK(converterEnable, 1'h0)
    nclk(1);
    thermalShutdown = 1'h0;
    #1 `CHK(converterEnable, 1'h1)
    trip = 6'h02;
    #1 `CHK(switchNodesHighZ, 1'h1)
    trip = 6'h00;
    #1 `CHK(switchNodesHighZ, 1'h0)
    for (int i = 0; i < 3; i++) begin
      nclk(1);
      fspm_host_model_inst.clearAll();
      {mask, trip} = {3'h1 << i, 6'h01};
      nclk(1);
      `CHK({faultSummary[5], converterEnable}, 2'h1)
      {mask, trip} = 9'h000;
    end
    hiccupEnable = 1'h1;
    trip = 6'h04;
    nclk(1);
    trip = 6'h00;
    `CHK(converterEnable, 1'h0)
    for (int n = 1; n < 20; n++) begin
      nclk(1);
      if (converterEnable === 1'h1) begin
        `CHK(n >= HIC && n <= HIC + 2, 1'h1)
        break;
      end
    end
    `CHK(converterEnable, 1'h1)
    hiccupEnable = 1'h0;
  endtask
  // input guard, input regulation and average limit
  task automatic tPower();
    {forcedPwmRequest, inputOvGuardEnable, inputRegulationEnable, inputOvAbove} = 4'hF;
    #1 `CHK(forcedPwmAllowed, 1'h0)
    inputOvAbove = 1'h0;
    #1 `CHK({forcedPwmAllowed, inputRegulationActive}, 2'h3)
    modePinLow = 1'h1;
    #1 `CHK(inputRegulationActive, 1'h0)
    {modePinLow, inputOvGuardEnable} = 2'h0;
    #1 `CHK(inputRegulationActive, 1'h0)
    avgLimitReached = 1'h1;
    #1 `CHK(avgLimitActive, 1'h0)
    avgLimitEnable = 1'h1;
    #1 `CHK(avgLimitActive, 1'h1)
    nclk(1);
    `CHK(pdStatusReg0, 8'h01)
  endtask
  // interrupt mode: every input change flips the pin
  task automatic tIrq();
    logic p;
    resetDut(4'h0, 1'h1);
    for (int i = 0; i < 3; i++) begin
      p = faultPinOe;
      if (i == 0) pdInputs = 8'h02;
      else trip = (i == 1) ? 6'h08 : 6'h00;
      nclk(2);
      `CHK(faultPinOe, ~p)
    end
  endtask
  // checksum mismatch at boot holds the converter off
  task automatic tCrc();
    checksumMismatch = 1'h1;
    resetDut(4'h0, 1'h0);
    checksumMismatch = 1'h0;
    nclk(2);
    `CHK({converterOffState, converterEnable, faultSummary[1]}, 3'h5)
    resetDut(4'h0, 1'h0);
    `CHK(converterOffState, 1'h0)
  endtask
  // decode captured once per reset; odd codes select spread spectrum
  task automatic tDecode();
    for (int c = 0; c < 17; c++) begin
      serialBusEnable = (c == 16);
      resetDut((c == 16) ? 4'h1 : c[3:0], 1'h0);
      `CHK({decodeValid, spreadSpectrumSelect}, {1'h1, c[0] & (c < 16)})
      configPinThreeCode = ~c[3:0];
      nclk(1);
      `CHK(spreadSpectrumSelect, c[0] & (c < 16))
    end
  endtask
  task automatic endSim();
    $display("comparisons %0d mismatches %0d", nTests, numErrors);
    if (numErrors == 0 && nTests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // main sequence; every input gets a value at time zero
  initial begin
    {core_clk, powerUpDone, serialBusEnable, startupDone, regFieldBusy, systemOff} = '0;
    {outputBelowPowerGood, thermalShutdown, checksumMismatch, bootDone, hiccupEnable} = '0;
    {avgLimitEnable, avgLimitReached, inputOvGuardEnable, inputOvAbove, modePinLow} = '0;
    {inputRegulationEnable, forcedPwmRequest, configPinThreeCode, pdInputs} = '0;
    {trip, mask, numErrors, nTests} = '0;
    rst = 1'h1;
    resetDut(4'h0, 1'h0);
    startupDone = 1'h1;
    tLatch();
    tBusyOff();
    tProtect();
    tPower();
    tIrq();
    tCrc();
    tDecode();
    endSim();
  end
  // watchdog far beyond the expected few hundred cycles
  initial begin
    #(5000 * 100);
    numErrors++;
    endSim();
  end
endmodule
`default_nettype wire
